/* rtl/selftest_params.svh */
// Offsets, codes and timing counts for the self-diagnosis block.
`ifndef SELFTEST_PARAMS_SVH
`define SELFTEST_PARAMS_SVH
`define MODE_REQ_OFS      12'h8cf
`define RESULT_OFS        12'h8d2
`define MODE_SELF_TEST    16'h0002
`define CODE_PASS         16'h0000
`define CODE_TIMER        16'h8001
`define CODE_IRQ          16'h8002
`define CODE_OPER         16'h8003
`define CODE_SRAM1        16'h8004
`define CODE_SRAM2        16'h8005
`define CODE_DPRAM        16'h8006
`define CODE_FLASH_ERASE  16'h800a
`define CODE_FLASH_SUM    16'h800b
`define CODE_SWAP         16'h8010
`define CTRL_OFS          4'h0
`define STATUS_OFS        4'h1
`define MASK_OFS          4'h2
`define RESULT_COPY_OFS   4'h3
`define MODE_OFS          4'h4
`define TEST_TIME_S       15
`define CLK_HZ            64'd200000000
`define TEST_CYCLES       (`TEST_TIME_S * `CLK_HZ)
`define NUM_TESTS         9
`define BLINK_CYCLES      32'd50000000
`endif

/* rtl/selftest_pkg.sv */
// State types for the link: diag_state_t for the module end, host_state_t for the host end.
package selftest_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b11
  } diag_state_t;
  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_WRITE = 2'b01,
    HS_HIGH  = 2'b11,
    HS_LOW   = 2'b10
  } host_state_t;
endpackage

/* rtl/selftest_if.sv */
// Buffer-memory port and indicators between host and module.
`timescale 1ns/1ps
interface selftest_if;
  logic        bm_wr;
  logic        bm_rd;
  logic [11:0] bm_addr;
  logic [15:0] bm_wdata;
  logic [15:0] bm_rdata;
  logic        mode_change_strobe;
  logic        test_indicator;
  logic        fault_indicator;
  modport device (
    input  bm_wr, bm_rd, bm_addr, bm_wdata, mode_change_strobe,
    output bm_rdata, test_indicator, fault_indicator
  );
  modport host (
    output bm_wr, bm_rd, bm_addr, bm_wdata, mode_change_strobe,
    input  bm_rdata, test_indicator, fault_indicator
  );
endinterface

/* rtl/selftest_device.sv */
// Module end: mode request word, test sequencer, indicators and result word.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "selftest_params.svh"
// ---------------------------------------------------------------------------
// Overview of operation
// - Whole test run lasts about fifteen seconds.
// - Host writes 02h into mode request word.
// - Host pulses mode strobe low-high-low.
// - Mode 2 starts tests without further command.
// - Test indicator on or blinking while running.
// - All pass turns test indicator off.
// - Any failure leaves test and fault on.
// - Result code written; zero means pass.
// - Timer, interrupt, operation fail 8001h-8003h.
// - SRAM1, SRAM2, dual-port RAM fail 8004h-8006h.
// - Flash erase 800Ah, checksum 800Bh.
// - Swap circuit failure reports 8010h.
// - Host resets CPU after passing run; the host block has no CPU reset and only sets status bit 0.
// - Host reads code and retries after failure.
// ---------------------------------------------------------------------------
module selftest_device
  import selftest_pkg::*;
#(
  parameter longint TEST_CYCLES  = `TEST_CYCLES,
  parameter int     BLINK_CYCLES = `BLINK_CYCLES
) (
  input  wire logic          ref_clk,
  input  wire logic          resetn,
  selftest_if.device         bm,
  input  wire logic [8:0]    unit_fail
);
  localparam longint STEP_CYCLES = TEST_CYCLES / `NUM_TESTS;

  logic [15:0]  mode_q;
  logic [15:0]  result_q;
  logic [15:0]  rdata_q;
  logic [2:0]   strobe_q;
  logic         strobe_d;
  diag_state_t  state_q;
  logic [3:0]   step_q;
  logic [63:0]  step_cnt_q;
  logic [31:0]  blink_cnt_q;
  logic         blink_q;
  logic         fail_q;
  logic [15:0]  fail_code;
  logic [15:0]  code_tab [0:8];

  assign code_tab[0] = `CODE_TIMER;
  assign code_tab[1] = `CODE_IRQ;
  assign code_tab[2] = `CODE_OPER;
  assign code_tab[3] = `CODE_SRAM1;
  assign code_tab[4] = `CODE_SRAM2;
  assign code_tab[5] = `CODE_DPRAM;
  assign code_tab[6] = `CODE_FLASH_ERASE;
  assign code_tab[7] = `CODE_FLASH_SUM;
  assign code_tab[8] = `CODE_SWAP;
  assign fail_code   = code_tab[step_q];

  // -------------------------------------------------------------------------
  // Buffer-memory access.
  // -------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= 16'h0000;
    end else if (bm.bm_wr && bm.bm_addr == `MODE_REQ_OFS) begin
      mode_q <= bm.bm_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 16'h0000;
    end else if (bm.bm_rd) begin
      unique case (bm.bm_addr)
        `MODE_REQ_OFS: rdata_q <= mode_q;
        `RESULT_OFS:   rdata_q <= result_q;
        default:       rdata_q <= 16'h0000;
      endcase
    end
  end
  assign bm.bm_rdata = rdata_q;

  // Strobe synchroniser; the falling edge completes the request.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      strobe_q <= 3'h0;
    end else begin
      strobe_q <= {strobe_q[1:0], bm.mode_change_strobe};
    end
  end
  assign strobe_d = strobe_q[2] && !strobe_q[1];

  // -------------------------------------------------------------------------
  // Test sequencer.
  // -------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q    <= ST_IDLE;
      step_q     <= 4'h0;
      step_cnt_q <= 64'h0;
      fail_q     <= 1'b0;
      result_q   <= `CODE_PASS;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (strobe_d && mode_q == `MODE_SELF_TEST) begin
            state_q    <= ST_RUN;
            step_q     <= 4'h0;
            step_cnt_q <= 64'h0;
            fail_q     <= 1'b0;
          end
        end
        ST_RUN: begin
          if (step_cnt_q >= 64'(STEP_CYCLES - 1)) begin
            step_cnt_q <= 64'h0;
            if (unit_fail[step_q]) begin
              fail_q   <= 1'b1;
              result_q <= fail_code;
              state_q  <= ST_DONE;
            end else if (step_q == 4'(`NUM_TESTS - 1)) begin
              result_q <= `CODE_PASS;
              state_q  <= ST_DONE;
            end else begin
              step_q <= step_q + 4'h1;
            end
          end else begin
            step_cnt_q <= step_cnt_q + 64'h1;
          end
        end
        ST_DONE: begin
          if (strobe_d && mode_q == `MODE_SELF_TEST) begin
            state_q    <= ST_RUN;
            step_q     <= 4'h0;
            step_cnt_q <= 64'h0;
            fail_q     <= 1'b0;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // Indicators.
  // -------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      blink_cnt_q <= 32'h0;
      blink_q     <= 1'b0;
    end else if (state_q != ST_RUN) begin
      blink_cnt_q <= 32'h0;
      blink_q     <= 1'b1;
    end else if (blink_cnt_q >= 32'(BLINK_CYCLES - 1)) begin
      blink_cnt_q <= 32'h0;
      blink_q     <= !blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bm.test_indicator  <= 1'b0;
      bm.fault_indicator <= 1'b0;
    end else begin
      bm.test_indicator  <= (state_q == ST_RUN) ? blink_q
                          : (state_q == ST_DONE) && fail_q;
      bm.fault_indicator <= (state_q == ST_DONE) && fail_q;
    end
  end
endmodule // selftest_device

/* rtl/selftest_host.sv */
// Host end: requests self-diagnosis and collects the outcome into registers.
`timescale 1ns/1ps
`include "selftest_params.svh"
module selftest_host
  import selftest_pkg::*;
#(
  parameter int QUIET_CYCLES = `BLINK_CYCLES + 2
) (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  selftest_if.host         bm,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  output logic             irq
);
  host_state_t hs_q;
  logic [1:0]  st_q;
  logic [1:0]  mask_q;
  logic [15:0] code_q;
  logic [15:0] mode_copy_q;
  logic        armed_q;
  logic [31:0] quiet_q;
  logic        ctr_q;
  logic        done_ev;
  logic        rd_pend_q;

  // A run ends on a raised fault or on a quiet spell longer than a blink.
  assign done_ev = armed_q && hs_q == HS_IDLE
                 && (bm.fault_indicator || quiet_q >= 32'(QUIET_CYCLES));

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      armed_q <= 1'b0;
      quiet_q <= 32'h0;
    end else begin
      if (done_ev) begin
        armed_q <= 1'b0;
      end else if (bm.test_indicator && !bm.fault_indicator) begin
        armed_q <= 1'b1;
      end
      if (!armed_q || done_ev || bm.test_indicator) begin
        quiet_q <= 32'h0;
      end else begin
        quiet_q <= quiet_q + 32'h1;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Request sequence toward the module.
  // -------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hs_q               <= HS_IDLE;
      bm.bm_wr           <= 1'b0;
      bm.bm_addr         <= 12'h000;
      bm.bm_wdata        <= 16'h0000;
      bm.mode_change_strobe <= 1'b0;
      ctr_q              <= 1'b0;
    end else begin
      bm.bm_wr <= 1'b0;
      ctr_q    <= 1'b0;
      unique case (hs_q)
        HS_IDLE: begin
          if (wr && addr == `CTRL_OFS && wdata[0]) begin
            hs_q        <= HS_WRITE;
            bm.bm_wr    <= 1'b1;
            bm.bm_addr  <= `MODE_REQ_OFS;
            bm.bm_wdata <= `MODE_SELF_TEST;
          end else if (done_ev) begin
            bm.bm_addr  <= `RESULT_OFS;
          end
        end
        HS_WRITE: begin
          bm.mode_change_strobe <= 1'b1;
          hs_q <= HS_HIGH;
        end
        HS_HIGH: begin
          ctr_q <= ~ctr_q;
          if (ctr_q) begin
            bm.mode_change_strobe <= 1'b0;
            hs_q <= HS_LOW;
          end
        end
        HS_LOW: hs_q <= HS_IDLE;
        default: hs_q <= HS_IDLE;
      endcase
    end
  end

  // Read the result code after each finished run.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bm.bm_rd  <= 1'b0;
      rd_pend_q <= 1'b0;
      code_q    <= 16'h0000;
    end else begin
      bm.bm_rd  <= done_ev;
      rd_pend_q <= bm.bm_rd;
      if (rd_pend_q) begin
        code_q <= bm.bm_rdata;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Software registers and interrupt.
  // -------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q   <= 2'b00;
      mask_q <= 2'b00;
    end else begin
      if (wr && addr == `MASK_OFS) begin
        mask_q <= wdata[1:0];
      end
      // Bit 0 run finished and passed, bit 1 run finished and failed.
      st_q <= ((rd && addr == `STATUS_OFS) ? 2'b00 : st_q)
            | {rd_pend_q && bm.fault_indicator,
               rd_pend_q && !bm.fault_indicator};
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata       <= 16'h0000;
      mode_copy_q <= 16'h0000;
    end else begin
      mode_copy_q <= {14'h0, bm.fault_indicator, bm.test_indicator};
      if (rd) begin
        unique case (addr)
          `STATUS_OFS:      rdata <= {14'h0, st_q};
          `MASK_OFS:        rdata <= {14'h0, mask_q};
          `RESULT_COPY_OFS: rdata <= code_q;
          `MODE_OFS:        rdata <= mode_copy_q;
          default:          rdata <= 16'h0000;
        endcase
      end
    end
  end
  assign irq = |(st_q & mask_q);
endmodule // selftest_host

/* verif/selftest_sva.sv */
// Checker for the host-to-module self-diagnosis link.
`timescale 1ns/1ps
`include "selftest_params.svh"
module selftest_sva #(
  parameter longint TEST_CYCLES  = 900,
  parameter int     BLINK_CYCLES = 10
) (
  input logic        ref_clk,
  input logic        resetn,
  input logic        bm_wr,
  input logic        bm_rd,
  input logic [11:0] bm_addr,
  input logic [15:0] bm_wdata,
  input logic        mode_change_strobe,
  input logic        test_indicator,
  input logic        fault_indicator
);
  localparam longint STEP = TEST_CYCLES / 9;
  logic   strobe_q;
  longint cyc_q;
  int     hi_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ------
  // Counters.
  // ------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      strobe_q <= 1'b0;
      cyc_q    <= 0;
      hi_q     <= 0;
    end else begin
      strobe_q <= mode_change_strobe;
      cyc_q    <= (strobe_q && !mode_change_strobe) ? 0 : cyc_q + 1;
      hi_q     <= (test_indicator && !fault_indicator) ? hi_q + 1 : 0;
    end
  end
  property p_mode; bm_wr && bm_addr == `MODE_REQ_OFS |-> bm_wdata == `MODE_SELF_TEST;
  endproperty
  a_mode: assert property (p_mode) else $error("bad mode word");
  property p_wr_first; $rose(mode_change_strobe) |-> $past(bm_wr); endproperty
  a_wr_first: assert property (p_wr_first) else $error("strobe before write");
  property p_pulse; $rose(mode_change_strobe) |-> mode_change_strobe[*2] ##1 !mode_change_strobe;
  endproperty
  a_pulse: assert property (p_pulse) else $error("bad strobe pulse");
  property p_start; $fell(mode_change_strobe) |-> ##[1:8] test_indicator; endproperty
  a_start: assert property (p_start) else $error("run did not start");
  property p_blink; hi_q <= BLINK_CYCLES + 1; endproperty
  a_blink: assert property (p_blink) else $error("indicator not blinking");
  property p_pair; fault_indicator |-> test_indicator; endproperty
  a_pair: assert property (p_pair) else $error("fault without test");
  property p_hold; $rose(fault_indicator) |-> fault_indicator[*8]; endproperty
  a_hold: assert property (p_hold) else $error("fault dropped");
  property p_len; $rose(fault_indicator) |-> cyc_q >= STEP && cyc_q <= TEST_CYCLES + 16;
  endproperty
  a_len: assert property (p_len) else $error("fault out of time");
  property p_rd; bm_rd |-> bm_addr == `RESULT_OFS; endproperty
  a_rd: assert property (p_rd) else $error("bad read address");
  c_pass: cover property ((!fault_indicator && !test_indicator) [*8]);
  c_fail: cover property ($rose(fault_indicator));
  c_retry: cover property (fault_indicator ##1 !fault_indicator);
endmodule // selftest_sva

/* verif/testbench.sv */
// Self-checking bench for both ends of the self-diagnosis link.
`timescale 1ns/1ps
`include "selftest_params.svh"
module testbench;
  localparam logic [15:0] CODES [10] = '{`CODE_TIMER, `CODE_IRQ, `CODE_OPER, `CODE_SRAM1,
    `CODE_SRAM2, `CODE_DPRAM, `CODE_FLASH_ERASE, `CODE_FLASH_SUM, `CODE_SWAP, `CODE_PASS};
  logic        ref_clk;
  logic        resetn;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        irq;
  logic [8:0]  unit_fail;
  logic [8:0]  uf;
  logic [15:0] d;
  logic [31:0] seed;
  int          n_fail;
  int          cmp_count;
  int          cyc;
  int          t;
  int          lo;
  int          k;
  int          n;
  selftest_if bm ();
  selftest_device #(.TEST_CYCLES(900), .BLINK_CYCLES(10)) i_selftest_device (
    .ref_clk(ref_clk), .resetn(resetn), .bm(bm), .unit_fail(unit_fail));
  selftest_host #(.QUIET_CYCLES(12)) i_selftest_host (.ref_clk(ref_clk), .resetn(resetn),
    .bm(bm), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  selftest_sva #(.TEST_CYCLES(900), .BLINK_CYCLES(10)) i_selftest_sva (
    .ref_clk(ref_clk), .resetn(resetn), .bm_wr(bm.bm_wr), .bm_rd(bm.bm_rd),
    .bm_addr(bm.bm_addr), .bm_wdata(bm.bm_wdata), .mode_change_strobe(bm.mode_change_strobe),
    .test_indicator(bm.test_indicator), .fault_indicator(bm.fault_indicator));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int first_fail(input logic [8:0] f);
    for (int j = 0; j < 9; j++) begin
      if (f[j])
        return j;
    end
    return 9;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      print_verdict();
    end
  end
  initial begin
    resetn    = 1'b0;
    addr      = '0;
    wdata     = '0;
    wr        = 1'b0;
    rd        = 1'b0;
    unit_fail = '0;
    seed      = 32'h82efdd7e;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    wr_reg(`MASK_OFS, 16'h0003);
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      uf = (i < 9) ? 9'h001 << i : (i == 9) ? 9'h000 : seed[8:0];
      unit_fail <= uf;
      k = first_fail(uf);
      n = (k < 9) ? (k + 1) * 100 : 900;
      wr_reg(`CTRL_OFS, 16'h0001);
      t = 0;
      lo = 0;
      while (!(bm.test_indicator && !bm.fault_indicator) && t < 40) begin
        @(posedge ref_clk);
        t++;
      end
      while (!bm.fault_indicator && lo < 15 && t < 2000) begin
        @(posedge ref_clk);
        t++;
        lo = bm.test_indicator ? 0 : lo + 1;
      end
      chk(16'(t >= n && t <= n + 30), 16'h0001);
      rd_reg(`MODE_OFS);
      chk(d, (k < 9) ? 16'h0003 : 16'h0000);
      chk(16'(irq), 16'h0001);
      rd_reg(`STATUS_OFS);
      if (k == 9) begin
        chk(d, 16'h0001);
        rd_reg(`RESULT_COPY_OFS);
        chk(d, `CODE_PASS);
        wr_reg(`STATUS_OFS, 16'h0000);
        rd_reg(`STATUS_OFS);
        chk(d, 16'h0000);
        #1 chk(16'(irq), 16'h0000);
      end else begin
        chk(d, 16'h0002);
        rd_reg(`RESULT_COPY_OFS);
        chk(d, CODES[k]);
      end
      $display("test %0d done", i);
    end
    print_verdict();
  end
endmodule // testbench
